// file: design/eeprom_loader_map.svh
`ifndef EEPROM_LOADER_MAP_SVH
`define EEPROM_LOADER_MAP_SVH

// ****************************************
// Serial memory link.
// ****************************************
`define EE_CMD_READ 3'h6
`define EE_CMD_LAST 5'h02
`define EE_ABITS_SMALL 4'h6
`define EE_ABITS_LARGE 4'h8
`define EE_DATA_LAST 5'h0f
`define EE_HALF_CYCLES 4
`define EE_GAP_CYCLES 8

// ****************************************
// Boot word list.
// ****************************************
`define EE_WORD_LAST 3'h6
`define EE_ADDR_STA0 8'h00
`define EE_ADDR_STA1 8'h01
`define EE_ADDR_STA2 8'h02
`define EE_ADDR_CFG 8'h0a
`define EE_ADDR_SUBSYS 8'h0b
`define EE_ADDR_VENDOR 8'h0c
`define EE_ADDR_RSV 8'h0d
`define IDX_STA0 3'h0
`define IDX_CFG 3'h3
`define IDX_SUBSYS 3'h4
`define IDX_VENDOR 3'h5
`define IDX_RSV 3'h6

// ****************************************
// Configuration word fields.
// ****************************************
`define CFG_SIG_HI 15
`define CFG_SIG_LO 14
`define CFG_SIG_OK 2'h1
`define CFG_REV_KEY_HI 15
`define CFG_REV_KEY_LO 13
`define CFG_REV_KEY 3'h3
`define CFG_BOOT_OFF 11
`define CFG_REV_HI 10
`define CFG_REV_LO 8
`define CFG_DPD 6
`define CFG_STB 1
`define DEF_BOOT_OFF 1'h0
`define DEF_DPD 1'h0
`define DEF_STB 1'h0
`define DEF_REV 3'h0

// ****************************************
// Register map.
// ****************************************
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_CFG 8'h08
`define REG_SUBSYS 8'h0c
`define REG_STA_LO 8'h10
`define REG_STA_HI 8'h14
`define REG_RSV 8'h18
`define CTRL_D3 0
`define CTRL_PME 1
`define CTRL_LOAD 2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: design/eeprom_loader_pkg.sv
package eeprom_loader_pkg;

  typedef enum logic [1:0] {
    BOOT_REQ = 2'b00,
    BOOT_WAIT = 2'b01,
    BOOT_DONE = 2'b10
  } boot_e;

  typedef enum logic [2:0] {
    L_IDLE = 3'b000,
    L_CMD = 3'b001,
    L_ADDR = 3'b010,
    L_DATA = 3'b011,
    L_GAP = 3'b100
  } link_e;

endpackage : eeprom_loader_pkg

// file: design/eeprom_serial_link.sv
`timescale 1ns/1ps
`include "eeprom_loader_map.svh"

module eeprom_serial_link import eeprom_loader_pkg::*; #(
  parameter int HALF = `EE_HALF_CYCLES,
  parameter int GAP = `EE_GAP_CYCLES
) (
  // Link clock and reset from the bus domain.
  input wire logic link_clk,
  input wire logic aresetn,
  // Request from the bus domain.
  input wire logic req_tgl,
  input wire logic [7:0] req_addr,
  input wire logic req_wide,
  input wire logic req_detect,
  // Answer to the bus domain.
  output logic done_tgl,
  output logic [15:0] rsp_data,
  output logic [3:0] rsp_abits,
  // Memory pins.
  output logic ee_cs,
  output logic ee_sk,
  output logic ee_di,
  input wire logic ee_do
);

  logic rst_s1, rst_s2, req_s1, req_s2, req_s3, do_s1, do_s2;
  link_e state;
  logic [3:0] hcnt;
  logic [4:0] bitcnt;
  logic [15:0] rx;
  logic [3:0] width;
  logic tick, addr_end, addr_bit;
  localparam logic [2:0] CMD_BITS = `EE_CMD_READ;

  always_ff @(posedge link_clk) begin
    rst_s1 <= aresetn;
    rst_s2 <= rst_s1;
    req_s1 <= req_tgl;
    req_s2 <= req_s1;
    do_s1 <= ee_do;
    do_s2 <= do_s1;
  end

  assign tick = (hcnt == 4'(HALF - 1));
  assign width = req_wide ? `EE_ABITS_LARGE : `EE_ABITS_SMALL;
  assign addr_end = ((bitcnt != 5'h00) && !do_s2)
    || (bitcnt[3:0] == (req_detect ? `EE_ABITS_LARGE : width));
  assign addr_bit = !req_detect && (bitcnt[3:0] < width)
    && req_addr[3'(width - bitcnt[3:0] - 4'h1)];

  always_ff @(posedge link_clk) begin
    if (!rst_s2) begin
      state <= L_IDLE;
      hcnt <= 4'h0;
      bitcnt <= 5'h00;
      rx <= 16'h0000;
      req_s3 <= 1'b0;
      done_tgl <= 1'b0;
      rsp_data <= 16'h0000;
      rsp_abits <= 4'h0;
      ee_cs <= 1'b0;
      ee_sk <= 1'b0;
      ee_di <= 1'b0;
    end else begin
      hcnt <= tick ? 4'h0 : hcnt + 4'h1;
      unique case (state)
        L_IDLE: begin
          hcnt <= 4'h0;
          if (req_s2 != req_s3) begin
            req_s3 <= req_s2;
            state <= L_CMD;
            ee_cs <= 1'b1;
            ee_di <= CMD_BITS[2];
            bitcnt <= 5'h00;
          end
        end
        L_GAP: begin
          hcnt <= hcnt + 4'h1;
          if (hcnt == 4'(GAP - 1)) state <= L_IDLE;
        end
        default: if (tick) begin
          ee_sk <= !ee_sk;
          if (!ee_sk) begin
            unique case (state)
              L_CMD: begin
                bitcnt <= (bitcnt == `EE_CMD_LAST) ? 5'h00 : bitcnt + 5'h01;
                if (bitcnt == `EE_CMD_LAST) state <= L_ADDR;
              end
              L_ADDR: begin
                if (addr_end) begin
                  state <= L_DATA;
                  rsp_abits <= bitcnt[3:0];
                  bitcnt <= 5'h00;
                end else begin
                  bitcnt <= bitcnt + 5'h01;
                end
              end
              default: begin
                rx <= {rx[14:0], do_s2};
                bitcnt <= bitcnt + 5'h01;
                if (bitcnt == `EE_DATA_LAST) begin
                  rsp_data <= {rx[14:0], do_s2};
                  done_tgl <= !done_tgl;
                  state <= L_GAP;
                  ee_cs <= 1'b0;
                  ee_sk <= 1'b0;
                  hcnt <= 4'h0;
                end
              end
            endcase
          end else begin
            unique case (state)
              L_CMD: ee_di <= CMD_BITS[2'(`EE_CMD_LAST - bitcnt)];
              L_ADDR: ee_di <= addr_bit;
              default: ee_di <= 1'b0;
            endcase
          end
        end
      endcase
    end
  end

endmodule : eeprom_serial_link

// file: design/serial_eeprom_config_loader.sv
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "eeprom_loader_map.svh"

module serial_eeprom_config_loader import eeprom_loader_pkg::*; #(
  parameter int HALF = `EE_HALF_CYCLES,
  parameter logic [2:0] DEF_REVISION = `DEF_REV
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel.
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  // Write data channel.
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // Write response channel.
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // Read address channel.
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  // Read data channel.
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Memory link.
  input wire logic link_clk,
  output logic ee_cs,
  output logic ee_sk,
  output logic ee_di,
  input wire logic ee_do,
  // Idle indication from the bus logic.
  input wire logic bus_idle,
  // Loaded configuration.
  output logic load_done,
  output logic [47:0] station_address,
  output logic boot_rom_window_off,
  output logic revision_override,
  output logic [2:0] revision_low_bits,
  output logic [15:0] subsystem_id,
  output logic [15:0] subsystem_vendor_id,
  output logic deep_sleep_inhibit,
  output logic idle_standby_allow,
  // Power control.
  output logic deep_power_down_allow,
  output logic standby_active,
  output logic clock_run_request
);

  // ****************************************
  // Link crossing.
  // ****************************************
  logic req_tgl;
  logic [7:0] req_addr;
  logic req_wide;
  logic req_detect;
  logic done_tgl;
  logic [15:0] rsp_data;
  logic [3:0] rsp_abits;
  logic dn_s1, dn_s2, dn_s3;
  logic done_ev;

  eeprom_serial_link #(
    .HALF(HALF)
  ) u_link (
    .link_clk(link_clk),
    .aresetn(aresetn),
    .req_tgl(req_tgl),
    .req_addr(req_addr),
    .req_wide(req_wide),
    .req_detect(req_detect),
    .done_tgl(done_tgl),
    .rsp_data(rsp_data),
    .rsp_abits(rsp_abits),
    .ee_cs(ee_cs),
    .ee_sk(ee_sk),
    .ee_di(ee_di),
    .ee_do(ee_do)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dn_s1 <= 1'b0;
      dn_s2 <= 1'b0;
      dn_s3 <= 1'b0;
    end else begin
      dn_s1 <= done_tgl;
      dn_s2 <= dn_s1;
      dn_s3 <= dn_s2;
    end
  end

  assign done_ev = dn_s2 ^ dn_s3;

  // ****************************************
  // Boot read sequence.
  // ****************************************
  boot_e state;
  logic [2:0] idx;
  logic size_known;
  logic size_large;
  logic [15:0] words [0:6];

  function automatic logic [7:0] word_addr(input logic [2:0] i);
    logic [7:0] a;
    a = `EE_ADDR_RSV;
    unique case (i)
      3'h0: a = `EE_ADDR_STA0;
      3'h1: a = `EE_ADDR_STA1;
      3'h2: a = `EE_ADDR_STA2;
      3'h3: a = `EE_ADDR_CFG;
      3'h4: a = `EE_ADDR_SUBSYS;
      3'h5: a = `EE_ADDR_VENDOR;
      default: a = `EE_ADDR_RSV;
    endcase
    return a;
  endfunction : word_addr

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= BOOT_REQ;
      idx <= 3'h0;
      req_tgl <= 1'b0;
      req_addr <= 8'h00;
      req_wide <= 1'b0;
      req_detect <= 1'b0;
      load_done <= 1'b0;
    end else begin
      unique case (state)
        BOOT_REQ: begin
          req_addr <= word_addr(idx);
          req_wide <= size_large;
          req_detect <= !size_known;
          req_tgl <= !req_tgl;
          state <= BOOT_WAIT;
        end
        BOOT_WAIT: begin
          if (done_ev) begin
            if (idx == `EE_WORD_LAST) begin
              state <= BOOT_DONE;
              load_done <= 1'b1;
            end else begin
              idx <= idx + 3'h1;
              state <= BOOT_REQ;
            end
          end
        end
        BOOT_DONE: state <= BOOT_DONE;
        default: state <= BOOT_REQ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      size_known <= 1'b0;
      size_large <= 1'b0;
    end else if (done_ev && !size_known) begin
      size_known <= 1'b1;
      size_large <= (rsp_abits != `EE_ABITS_SMALL);
    end
  end

  generate
    for (genvar g = 0; g < 7; g++) begin : g_word
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          words[g] <= 16'h0000;
        end else if (done_ev && state == BOOT_WAIT && idx == 3'(g)) begin
          words[g] <= rsp_data;
        end
      end
    end
  endgenerate

  // ****************************************
  // Configuration decode.
  // ****************************************
  logic [15:0] cfg;
  logic cfg_ok;
  logic rev_ok;

  assign cfg = words[`IDX_CFG];
  assign cfg_ok = load_done && (cfg[`CFG_SIG_HI:`CFG_SIG_LO] == `CFG_SIG_OK);
  assign rev_ok = cfg_ok && (cfg[`CFG_REV_KEY_HI:`CFG_REV_KEY_LO] == `CFG_REV_KEY);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_rom_window_off <= `DEF_BOOT_OFF;
      revision_override <= 1'b0;
      revision_low_bits <= DEF_REVISION;
      deep_sleep_inhibit <= `DEF_DPD;
      idle_standby_allow <= `DEF_STB;
      subsystem_id <= 16'h0000;
      subsystem_vendor_id <= 16'h0000;
    end else begin
      boot_rom_window_off <= cfg_ok ? cfg[`CFG_BOOT_OFF] : `DEF_BOOT_OFF;
      revision_override <= rev_ok;
      revision_low_bits <= rev_ok ? cfg[`CFG_REV_HI:`CFG_REV_LO] : DEF_REVISION;
      deep_sleep_inhibit <= cfg_ok ? cfg[`CFG_DPD] : `DEF_DPD;
      idle_standby_allow <= cfg_ok ? cfg[`CFG_STB] : `DEF_STB;
      subsystem_id <= load_done ? words[`IDX_SUBSYS] : 16'h0000;
      subsystem_vendor_id <= load_done ? words[`IDX_VENDOR] : 16'h0000;
    end
  end

  // ****************************************
  // Power control.
  // ****************************************
  logic ctrl_d3;
  logic ctrl_pme;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      deep_power_down_allow <= 1'b0;
      standby_active <= 1'b0;
      clock_run_request <= 1'b1;
    end else begin
      deep_power_down_allow <= ctrl_d3 && !ctrl_pme && !deep_sleep_inhibit;
      standby_active <= idle_standby_allow && bus_idle;
      clock_run_request <= !(idle_standby_allow && bus_idle);
    end
  end

  // ****************************************
  // Register bus.
  // ****************************************
  logic aw_got, w_got, w_fire;
  logic next_aw_got, next_w_got, next_rvalid;
  logic [7:0] waddr;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [47:0] sta_shadow;
  logic sw_owned;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [31:0] sta_hi_merge;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : merge

  assign sta_hi_merge = merge({16'h0000, sta_shadow[47:32]}, wdata_q, wstrb_q);
  assign w_fire = aw_got && w_got && !bvalid;

  always_comb begin
    next_aw_got = (aw_got || (awvalid && awready)) && !w_fire;
    next_w_got = (w_got || (wvalid && wready)) && !w_fire;
    next_rvalid = (rvalid && !rready) || (arvalid && arready);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      waddr <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      awready <= !next_aw_got;
      wready <= !next_w_got;
      if (awvalid && awready) waddr <= awaddr;
      if (wvalid && wready) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (w_fire) begin
        bvalid <= 1'b1;
        bresp <= (waddr[7:2] <= `REG_RSV >> 2) && (waddr[1:0] == 2'h0)
          ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_d3 <= 1'b0;
      ctrl_pme <= 1'b0;
      sta_shadow <= 48'h0000_0000_0000;
      station_address <= 48'h0000_0000_0000;
      sw_owned <= 1'b0;
    end else begin
      if (w_fire && waddr == `REG_CTRL && wstrb_q[0]) begin
        ctrl_d3 <= wdata_q[`CTRL_D3];
        ctrl_pme <= wdata_q[`CTRL_PME];
      end
      if (w_fire && waddr == `REG_STA_LO) begin
        sta_shadow[31:0] <= merge(sta_shadow[31:0], wdata_q, wstrb_q);
      end
      if (w_fire && waddr == `REG_STA_HI) begin
        sta_shadow[47:32] <= sta_hi_merge[15:0];
      end
      if (w_fire && waddr == `REG_CTRL && wstrb_q[0] && wdata_q[`CTRL_LOAD]) begin
        station_address <= sta_shadow;
        sw_owned <= 1'b1;
      end else if (done_ev && state == BOOT_WAIT && !sw_owned
                   && idx == `EE_WORD_LAST) begin
        station_address <= {words[2], words[1], words[0]};
      end
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = `RESP_OKAY;
    unique case (araddr)
      `REG_CTRL: next_rdata = {30'h0000_0000, ctrl_pme, ctrl_d3};
      `REG_STATUS: next_rdata = {24'h00_0000, state == BOOT_DONE, revision_override,
                                 deep_power_down_allow, standby_active, sw_owned,
                                 cfg_ok, size_large, load_done};
      `REG_CFG: next_rdata = {16'h0000, cfg};
      `REG_SUBSYS: next_rdata = {subsystem_vendor_id, subsystem_id};
      `REG_STA_LO: next_rdata = station_address[31:0];
      `REG_STA_HI: next_rdata = {16'h0000, station_address[47:32]};
      `REG_RSV: next_rdata = {16'h0000, words[`IDX_RSV]};
      default: next_rresp = `RESP_SLVERR;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else begin
      arready <= !next_rvalid;
      rvalid <= next_rvalid;
      if (arvalid && arready) begin
        rdata <= next_rdata;
        rresp <= next_rresp;
      end
    end
  end

endmodule : serial_eeprom_config_loader

// file: verification/loader_checker.sv
`timescale 1ns/1ps

module loader_checker #(
  parameter int HALF = 4,
  parameter logic [2:0] DEF_REVISION = 3'h0
) (
  // Clocks and reset.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic link_clk,
  // Bus.
  input wire logic bvalid,
  // Memory link.
  input wire logic ee_cs,
  input wire logic ee_sk,
  input wire logic ee_di,
  // Configuration and power.
  input wire logic bus_idle,
  input wire logic load_done,
  input wire logic [47:0] station_address,
  input wire logic [15:0] subsystem_id,
  input wire logic revision_override,
  input wire logic [2:0] revision_low_bits,
  input wire logic deep_sleep_inhibit,
  input wire logic idle_standby_allow,
  input wire logic deep_power_down_allow,
  input wire logic standby_active,
  input wire logic clock_run_request
);
  int hi_cnt;

  // ****
  // Serial clock high-time counter.
  // ****
  always_ff @(posedge link_clk) begin
    if (!aresetn) hi_cnt <= 0;
    else hi_cnt <= ee_sk ? hi_cnt + 1 : 0;
  end

  // ****
  // Link properties.
  // ****
  property p_cmd_start;
    @(posedge link_clk) disable iff (!aresetn) $rose(ee_cs) |-> ee_di && !ee_sk;
  endproperty
  a_cmd_start: assert property (p_cmd_start) else $error("bad transfer start");
  property p_di_stable;
    @(posedge link_clk) disable iff (!aresetn) $rose(ee_sk) |-> $stable(ee_di);
  endproperty
  a_di_stable: assert property (p_di_stable) else $error("data moved at clock rise");
  property p_sk_half;
    @(posedge link_clk) disable iff (!aresetn) $fell(ee_sk) && ee_cs |-> hi_cnt == HALF;
  endproperty
  a_sk_half: assert property (p_sk_half) else $error("serial high time wrong");
  property p_cs_sk;
    @(posedge link_clk) disable iff (!aresetn) $rose(ee_sk) |-> ee_cs;
  endproperty
  a_cs_sk: assert property (p_cs_sk) else $error("serial clock without select");

  // ****
  // Configuration properties.
  // ****
  property p_rev_default;
    @(posedge aclk) disable iff (!aresetn) !revision_override |->
      revision_low_bits == DEF_REVISION;
  endproperty
  a_rev_default: assert property (p_rev_default) else $error("revision not default");
  property p_blank;
    @(posedge aclk) disable iff (!aresetn) !load_done |->
      station_address == 48'h0000_0000_0000 && subsystem_id == 16'h0000;
  endproperty
  a_blank: assert property (p_blank) else $error("words shown before load");
  property p_sta_hold;
    @(posedge aclk) disable iff (!aresetn)
      $past(load_done) && load_done && $changed(station_address) |-> $rose(bvalid);
  endproperty
  a_sta_hold: assert property (p_sta_hold) else $error("address changed unasked");
  property p_dpd;
    @(posedge aclk) disable iff (!aresetn)
      deep_power_down_allow && $stable(deep_sleep_inhibit) |-> !deep_sleep_inhibit;
  endproperty
  a_dpd: assert property (p_dpd) else $error("deep sleep allowed while inhibited");
  property p_standby;
    @(posedge aclk) disable iff (!aresetn) idle_standby_allow && bus_idle &&
      $past(idle_standby_allow) && $past(bus_idle) |-> standby_active;
  endproperty
  a_standby: assert property (p_standby) else $error("standby not entered");
  property p_active;
    @(posedge aclk) disable iff (!aresetn) !idle_standby_allow && !$past(idle_standby_allow)
      |-> !standby_active && clock_run_request;
  endproperty
  a_active: assert property (p_active) else $error("left active state");

  c_load: cover property (@(posedge aclk) $rose(load_done));
  c_standby: cover property (@(posedge aclk) $rose(standby_active));
  c_dpd: cover property (@(posedge aclk) $rose(deep_power_down_allow));
  c_sta: cover property (@(posedge aclk) load_done && $changed(station_address));
endmodule : loader_checker

bind serial_eeprom_config_loader loader_checker #(.HALF(HALF), .DEF_REVISION(DEF_REVISION))
  loader_checker_inst (.aclk, .aresetn, .link_clk, .bvalid, .ee_cs, .ee_sk, .ee_di,
  .bus_idle, .load_done, .station_address, .subsystem_id, .revision_override,
  .revision_low_bits, .deep_sleep_inhibit, .idle_standby_allow, .deep_power_down_allow,
  .standby_active, .clock_run_request);

// file: verification/eeprom_chip_model.sv
`timescale 1ns/1ps
`include "eeprom_loader_map.svh"

module eeprom_chip_model (
  // Memory pins.
  input wire logic ee_cs,
  input wire logic ee_sk,
  input wire logic ee_di,
  output logic ee_do,
  // Memory set-up.
  input wire logic wide,
  input wire logic [15:0] word_cfg
);
  int cnt;
  int abits;
  logic [2:0] cmd;
  logic [7:0] addr;
  logic [15:0] sh;

  initial ee_do = 1'b1;

  // ****
  // Serial read responder; the data line idles at its pull-up level.
  // ****
  always @(posedge ee_sk or negedge ee_cs) begin
    abits = wide ? 8 : 6;
    if (!ee_cs) begin
      cnt = 0;
      cmd = 3'h0;
      addr = 8'h00;
      ee_do <= 1'b1;
    end else begin
      cnt = cnt + 1;
      if (cnt <= 3) cmd = {cmd[1:0], ee_di};
      else if (cnt <= 3 + abits) addr = {addr[6:0], ee_di};
      if (cmd == `EE_CMD_READ && cnt == 3 + abits) ee_do <= 1'b0;
      else if (cmd == `EE_CMD_READ && cnt > 3 + abits && cnt < 20 + abits) begin
        sh = (cnt == 4 + abits) ? (addr == 8'h0a ? word_cfg : {addr, ~addr}) : sh << 1;
        ee_do <= sh[15];
      end else ee_do <= 1'b1;
    end
  end
endmodule : eeprom_chip_model

// file: verification/serial_eeprom_config_loader_test.sv
`timescale 1ns/1ps
`include "eeprom_loader_map.svh"

module serial_eeprom_config_loader_test import eeprom_loader_pkg::*;;
  logic aclk, aresetn, link_clk, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, ee_cs, ee_sk, ee_di, ee_do, bus_idle, wide;
  logic load_done, boot_rom_window_off, revision_override, deep_sleep_inhibit;
  logic idle_standby_allow, deep_power_down_allow, standby_active, clock_run_request;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic [47:0] station_address;
  logic [2:0] revision_low_bits;
  logic [15:0] subsystem_id, subsystem_vendor_id, word_cfg;
  logic [15:0] boot_cfg [3] = '{16'h6b02, 16'h4d40, 16'hab42};
  logic boot_wide [3] = '{1'b0, 1'b1, 1'b0};
  int miscompares, num_checks;

  serial_eeprom_config_loader #(.HALF(4)) serial_eeprom_config_loader_inst (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .link_clk, .ee_cs, .ee_sk, .ee_di, .ee_do, .bus_idle, .load_done,
    .station_address, .boot_rom_window_off, .revision_override, .revision_low_bits,
    .subsystem_id, .subsystem_vendor_id, .deep_sleep_inhibit, .idle_standby_allow,
    .deep_power_down_allow, .standby_active, .clock_run_request
  );
  eeprom_chip_model eeprom_chip_model_inst (.ee_cs, .ee_sk, .ee_di, .ee_do, .wide, .word_cfg);

  // ****
  // Clocks.
  // ****
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #32 link_clk = ~link_clk;
  end

  // ****
  // Checking and bus tasks.
  // ****
  function automatic logic [15:0] word_at(input logic [7:0] a);
    return {a, ~a};
  endfunction : word_at

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict;
    if (miscompares == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        done = 1'b1;
      end
    end
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        done = 1'b1;
      end
    end
    rready <= 1'b0;
  endtask : axi_read

  // ****
  // One boot with a given memory size and configuration word.
  // ****
  task automatic boot(input logic w, input logic [15:0] c);
    logic valid, key, stb;
    logic [47:0] sta;
    int n;
    valid = c[15:14] == 2'h1;
    key = valid && c[15:13] == 3'h3;
    stb = valid & c[1];
    sta = {word_at(8'h02), word_at(8'h01), word_at(8'h00)};
    @(posedge aclk);
    aresetn <= 1'b0;
    wide <= w;
    word_cfg <= c;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    n = 0;
    while (load_done !== 1'b1 && n < 8000) begin
      @(posedge aclk);
      n++;
    end
    repeat (2) @(posedge aclk);
    check(load_done, 1'b1);
    check(station_address, sta);
    check(subsystem_id, word_at(8'h0b));
    check(subsystem_vendor_id, word_at(8'h0c));
    check(boot_rom_window_off, valid & c[11]);
    check(revision_override, key);
    check(revision_low_bits, key ? c[10:8] : 3'h0);
    check(deep_sleep_inhibit, valid & c[6]);
    check(idle_standby_allow, stb);
    axi_read(`REG_STATUS, rd, rsp);
    check(rd[2:0], {valid, w, 1'b1});
    axi_read(`REG_CFG, rd, rsp);
    check(rd, {16'h0000, c});
    axi_read(`REG_RSV, rd, rsp);
    check(rd, {16'h0000, word_at(8'h0d)});
    bus_idle <= 1'b1;
    repeat (3) @(posedge aclk);
    check(standby_active, stb);
    check(clock_run_request, !stb);
    bus_idle <= 1'b0;
    axi_write(`REG_CTRL, 32'h0000_0001, rsp);
    repeat (3) @(posedge aclk);
    check(deep_power_down_allow, !(valid & c[6]));
    axi_write(`REG_CTRL, 32'h0000_0003, rsp);
    repeat (3) @(posedge aclk);
    check(deep_power_down_allow, 1'b0);
    axi_write(`REG_STA_LO, 32'h1234_5678, rsp);
    check(rsp, `RESP_OKAY);
    axi_write(`REG_STA_HI, 32'h0000_9abc, rsp);
    check(station_address, sta);
    axi_write(`REG_CTRL, 32'h0000_0004, rsp);
    repeat (2) @(posedge aclk);
    check(station_address, 48'h9abc_1234_5678);
    axi_read(`REG_STA_LO, rd, rsp);
    check(rd, 32'h1234_5678);
    axi_read(8'h40, rd, rsp);
    check(rsp, `RESP_SLVERR);
    axi_write(8'h44, 32'h0000_0001, rsp);
    check(rsp, `RESP_SLVERR);
  endtask : boot

  // ****
  // Main sequence and watchdog.
  // ****
  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hf;
    bus_idle = 1'b0;
    wide = 1'b0;
    word_cfg = 16'h0000;
    miscompares = 0;
    num_checks = 0;
    for (int i = 0; i < 3; i++) begin
      boot(boot_wide[i], boot_cfg[i]);
    end
    print_verdict();
  end

  initial begin
    repeat (40000) @(posedge aclk);
    miscompares++;
    print_verdict();
  end
endmodule : serial_eeprom_config_loader_test
